/* src/itm_counter.sv */
`timescale 1ns/100ps
`default_nettype none
module itm_counter
    import itm_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic                 reset,
    input  wire logic                 load,
    input  wire logic [ITM_CNT_W-1:0] load_value,
    input  wire logic                 start,
    input  wire logic                 stop,
    input  wire logic                 continuous,
    output logic      [ITM_CNT_W-1:0] count,
    output logic                      running,
    output logic                      zero_hit
);
    itm_cnt_state_t s_q;
    itm_cnt_state_t s_d;

    // counter sits at zero for one cycle, so the true period is value plus one
    assign zero_hit = (s_q.run == ITM_RUNNING) && (s_q.count == ITM_CNT_ZERO);
    assign count    = s_q.count;
    assign running  = (s_q.run == ITM_RUNNING);

    // a period write loads and stops; stop beats start when both are written
    always_comb begin
        s_d = s_q;
        case (s_q.run)
            ITM_RUNNING: begin
                if (zero_hit) begin
                    s_d.count = load_value;
                    if (!continuous) begin
                        s_d.run = ITM_STOPPED;
                    end
                end else begin
                    s_d.count = s_q.count - ITM_CNT_ONE;
                end
            end
            ITM_STOPPED: begin
                s_d.run = ITM_STOPPED;
            end
            default: begin
                s_d.run = ITM_STOPPED;
            end
        endcase
        if (start) begin
            s_d.run = ITM_RUNNING;
        end
        if (stop) begin
            s_d.run = ITM_STOPPED;
        end
        if (load) begin
            s_d.count = load_value;
            s_d.run   = ITM_STOPPED;
        end
    end

    // stopped and preloaded with the reset period
    always_ff @(posedge clock) begin
        if (reset) begin
            s_q.count <= ITM_PERIOD_RESET;
            s_q.run   <= ITM_STOPPED;
        end else begin
            s_q <= s_d;
        end
    end
endmodule
`default_nettype wire

/* src/itm_pkg.sv */
package itm_pkg;
    // bus geometry
    localparam int unsigned ITM_ADDR_W = 3;
    localparam int unsigned ITM_DATA_W = 16;
    localparam int unsigned ITM_CNT_W  = 32;

    // register word offsets
    localparam logic [ITM_ADDR_W-1:0] ITM_OFS_STATUS    = 3'h0;
    localparam logic [ITM_ADDR_W-1:0] ITM_OFS_CONTROL   = 3'h1;
    localparam logic [ITM_ADDR_W-1:0] ITM_OFS_PERIOD_LO = 3'h2;
    localparam logic [ITM_ADDR_W-1:0] ITM_OFS_PERIOD_HI = 3'h3;
    localparam logic [ITM_ADDR_W-1:0] ITM_OFS_SNAP_LO   = 3'h4;
    localparam logic [ITM_ADDR_W-1:0] ITM_OFS_SNAP_HI   = 3'h5;

    // status field positions
    localparam int unsigned ITM_BIT_TIMEOUT = 0;
    localparam int unsigned ITM_BIT_RUN     = 1;
    // control field positions
    localparam int unsigned ITM_BIT_IRQ_EN     = 0;
    localparam int unsigned ITM_BIT_CONTINUOUS = 1;
    localparam int unsigned ITM_BIT_START      = 2;
    localparam int unsigned ITM_BIT_STOP       = 3;

    // reset values and counter constants
    localparam logic [ITM_CNT_W-1:0]  ITM_PERIOD_RESET = 32'hFFFF_FFFF;
    localparam logic [ITM_CNT_W-1:0]  ITM_CNT_ZERO     = 32'h0000_0000;
    localparam logic [ITM_CNT_W-1:0]  ITM_CNT_ONE      = 32'h0000_0001;
    localparam logic [ITM_DATA_W-1:0] ITM_DATA_ZERO    = 16'h0000;

    typedef enum logic [0:0] {
        ITM_STOPPED = 1'b0,
        ITM_RUNNING = 1'b1
    } itm_run_t;

    typedef struct packed {
        logic [ITM_CNT_W-1:0] count;
        itm_run_t             run;
    } itm_cnt_state_t;

    typedef struct packed {
        logic                  timeout_flag;
        logic                  irq_on_timeout_enable;
        logic                  continuous_mode;
        logic [ITM_DATA_W-1:0] period_low;
        logic [ITM_DATA_W-1:0] period_high;
        logic [ITM_DATA_W-1:0] snapshot_low;
        logic [ITM_DATA_W-1:0] snapshot_high;
        logic [ITM_DATA_W-1:0] read_data;
    } itm_reg_state_t;
endpackage

/* src/itm_top.sv */
`timescale 1ns/100ps
`default_nettype none
// Function
// - six 16-bit registers at word offsets 0 to 5 on the slave port.
// - unused read bits return zero; the master writes zeros there.
// - offset 2 holds low half of period, timeout minus one.
// - offset 3 holds high half of period, forming 32-bit value.
// - snapshot of counter readable, low half at 4, high at 5.
// - timeout flag in status bit 0 sets when the counter reaches zero.
// - timeout flag stays set until the master clears it.
// - writing zero to status clears the timeout flag.
// - status bit 1 reads one while counting, zero when stopped.
// - status writes do not change the running bit.
// - interrupt while irq enable bit and timeout flag are both one.
// - continuous bit keeps counting after zero; counter always reloads at zero.
// - writing one to start starts, one to stop stops; zeros ignored.
// - write to either snapshot register captures whole counter into both.
module itm_top
    import itm_pkg::*;
(
    input  wire logic                  clock,
    input  wire logic                  reset,
    input  wire logic [ITM_ADDR_W-1:0] address,
    input  wire logic                  chipselect,
    input  wire logic                  write,
    input  wire logic                  read,
    input  wire logic [ITM_DATA_W-1:0] writedata,
    output logic      [ITM_DATA_W-1:0] readdata,
    output logic                       irq
);
    itm_reg_state_t r_q;
    itm_reg_state_t r_d;

    logic [ITM_CNT_W-1:0] count;
    logic                 running;
    logic                 zero_hit;
    logic                 wr_req;
    logic                 wr_status;
    logic                 wr_control;
    logic                 wr_period;
    logic                 wr_snap;
    logic                 clr_timeout;

    // one decode shared by every write strobe; the bus comes in as arguments,
    // since a continuous assignment only wakes up when an argument moves
    function automatic logic wr_hit(input logic                  req,
                                    input logic [ITM_ADDR_W-1:0] addr,
                                    input logic [ITM_ADDR_W-1:0] ofs);
        return req && (addr == ofs);
    endfunction

    assign wr_req      = chipselect && write;
    assign wr_status   = wr_hit(wr_req, address, ITM_OFS_STATUS);
    assign wr_control  = wr_hit(wr_req, address, ITM_OFS_CONTROL);
    assign wr_period   = wr_hit(wr_req, address, ITM_OFS_PERIOD_LO) || wr_hit(wr_req, address, ITM_OFS_PERIOD_HI);
    assign wr_snap     = wr_hit(wr_req, address, ITM_OFS_SNAP_LO) || wr_hit(wr_req, address, ITM_OFS_SNAP_HI);
    assign clr_timeout = wr_status && !writedata[ITM_BIT_TIMEOUT];

    // counter loads from the register values being written this cycle
    itm_counter u_counter (
        .clock      (clock),
        .reset      (reset),
        .load       (wr_period),
        .load_value ({r_d.period_high, r_d.period_low}),
        .start      (wr_control && writedata[ITM_BIT_START]),
        .stop       (wr_control && writedata[ITM_BIT_STOP]),
        .continuous (r_q.continuous_mode),
        .count      (count),
        .running    (running),
        .zero_hit   (zero_hit)
    );

    assign irq      = r_q.irq_on_timeout_enable && r_q.timeout_flag;
    assign readdata = r_q.read_data;

    // register writes, flag update and registered read data
    always_comb begin
        r_d = r_q;
        if (clr_timeout) begin
            r_d.timeout_flag = 1'b0;
        end
        // set wins so a zero crossing during a clear is not lost
        if (zero_hit) begin
            r_d.timeout_flag = 1'b1;
        end
        if (wr_control) begin
            r_d.irq_on_timeout_enable = writedata[ITM_BIT_IRQ_EN];
            r_d.continuous_mode       = writedata[ITM_BIT_CONTINUOUS];
        end
        if (wr_hit(wr_req, address, ITM_OFS_PERIOD_LO)) begin
            r_d.period_low = writedata;
        end
        if (wr_hit(wr_req, address, ITM_OFS_PERIOD_HI)) begin
            r_d.period_high = writedata;
        end
        if (wr_snap) begin
            r_d.snapshot_low  = count[ITM_DATA_W-1:0];
            r_d.snapshot_high = count[ITM_CNT_W-1:ITM_DATA_W];
        end
        // unused bits read as zero, so writing zeros there is always harmless
        r_d.read_data = ITM_DATA_ZERO;
        if (chipselect && read) begin
            case (address)
                ITM_OFS_STATUS: begin
                    r_d.read_data[ITM_BIT_TIMEOUT] = r_q.timeout_flag;
                    r_d.read_data[ITM_BIT_RUN]     = running;
                end
                ITM_OFS_CONTROL: begin
                    r_d.read_data[ITM_BIT_IRQ_EN]     = r_q.irq_on_timeout_enable;
                    r_d.read_data[ITM_BIT_CONTINUOUS] = r_q.continuous_mode;
                end
                ITM_OFS_PERIOD_LO: begin
                    r_d.read_data = r_q.period_low;
                end
                ITM_OFS_PERIOD_HI: begin
                    r_d.read_data = r_q.period_high;
                end
                ITM_OFS_SNAP_LO: begin
                    r_d.read_data = r_q.snapshot_low;
                end
                ITM_OFS_SNAP_HI: begin
                    r_d.read_data = r_q.snapshot_high;
                end
                default: begin
                    r_d.read_data = ITM_DATA_ZERO;
                end
            endcase
        end
    end

    // reset loads the period with all ones and clears all other state, including the read data
    always_ff @(posedge clock) begin
        if (reset) begin
            r_q.timeout_flag          <= 1'b0;
            r_q.irq_on_timeout_enable <= 1'b0;
            r_q.continuous_mode       <= 1'b0;
            r_q.period_low            <= ITM_PERIOD_RESET[ITM_DATA_W-1:0];
            r_q.period_high           <= ITM_PERIOD_RESET[ITM_CNT_W-1:ITM_DATA_W];
            r_q.snapshot_low          <= ITM_DATA_ZERO;
            r_q.snapshot_high         <= ITM_DATA_ZERO;
            r_q.read_data             <= ITM_DATA_ZERO;
        end else begin
            r_q <= r_d;
        end
    end

    // checks on the register interface and counter coupling
    property p_period_low;
        @(posedge clock) disable iff (reset)
        wr_hit(wr_req, address, ITM_OFS_PERIOD_LO) |=> (r_q.period_low == $past(writedata));
    endproperty
    a_period_low: assert property (p_period_low) else $error("period low not stored");

    property p_period_high;
        @(posedge clock) disable iff (reset)
        wr_hit(wr_req, address, ITM_OFS_PERIOD_HI) |=> (r_q.period_high == $past(writedata)) && !running;
    endproperty
    a_period_high: assert property (p_period_high) else $error("period high not stored");

    property p_snapshot;
        @(posedge clock) disable iff (reset)
        wr_snap |=> ({r_q.snapshot_high, r_q.snapshot_low} == $past(count));
    endproperty
    a_snapshot: assert property (p_snapshot) else $error("snapshot not coherent");

    property p_snap_read;
        @(posedge clock) disable iff (reset)
        chipselect && read && !write && address == ITM_OFS_SNAP_HI |=> readdata == $past(r_q.snapshot_high);
    endproperty
    a_snap_read: assert property (p_snap_read) else $error("snapshot high read wrong");

    property p_timeout_set;
        @(posedge clock) disable iff (reset)
        zero_hit |=> r_q.timeout_flag;
    endproperty
    a_timeout_set: assert property (p_timeout_set) else $error("timeout flag not set at zero");

    property p_timeout_sticky;
        @(posedge clock) disable iff (reset)
        r_q.timeout_flag && !clr_timeout |=> r_q.timeout_flag;
    endproperty
    a_timeout_sticky: assert property (p_timeout_sticky) else $error("timeout flag dropped");

    property p_timeout_clear;
        @(posedge clock) disable iff (reset)
        clr_timeout && !zero_hit |=> !r_q.timeout_flag;
    endproperty
    a_timeout_clear: assert property (p_timeout_clear) else $error("timeout flag not cleared");

    property p_run_read;
        @(posedge clock) disable iff (reset)
        chipselect && read && address == ITM_OFS_STATUS |=> readdata[ITM_BIT_RUN] == $past(running);
    endproperty
    a_run_read: assert property (p_run_read) else $error("run bit misreported");

    property p_status_wr_run;
        @(posedge clock) disable iff (reset)
        wr_status && !zero_hit && !wr_control && !wr_period |=> running == $past(running);
    endproperty
    a_status_wr_run: assert property (p_status_wr_run) else $error("status write moved run");

    property p_irq;
        @(posedge clock) disable iff (reset)
        zero_hit && r_q.irq_on_timeout_enable && !wr_control |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing after timeout");

    property p_one_shot;
        @(posedge clock) disable iff (reset)
        zero_hit && !r_q.continuous_mode && !wr_control
            |=> !running && count == $past({r_d.period_high, r_d.period_low});
    endproperty
    a_one_shot: assert property (p_one_shot) else $error("one-shot did not stop and reload");

    property p_start;
        @(posedge clock) disable iff (reset)
        // a zero crossing in one-shot, a period write or a stop may end the run early
        wr_control && writedata[ITM_BIT_START] && !writedata[ITM_BIT_STOP]
            |=> running ##1 (running || $past(zero_hit || wr_period || wr_control));
    endproperty
    a_start: assert property (p_start) else $error("start write ignored");

    property p_reset_read;
        @(posedge clock)
        reset |=> readdata == ITM_DATA_ZERO && !r_q.timeout_flag && !running;
    endproperty
    a_reset_read: assert property (p_reset_read) else $error("reset state wrong");

    property p_unused_zero;
        @(posedge clock) disable iff (reset)
        chipselect && read && address == ITM_OFS_STATUS |=> readdata[ITM_DATA_W-1:ITM_BIT_RUN+1] == '0;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused status bits nonzero");

    c_timeout:   cover property (@(posedge clock) disable iff (reset) zero_hit ##1 irq);
    c_continue:  cover property (@(posedge clock) disable iff (reset) zero_hit && r_q.continuous_mode ##1 running);
    c_clear_irq: cover property (@(posedge clock) disable iff (reset) irq ##1 clr_timeout ##1 !irq);
    c_snapshot:  cover property (@(posedge clock) disable iff (reset) running && wr_snap);
endmodule
`default_nettype wire

/* tb/itm_bus_master.sv */
`timescale 1ns/100ps
`default_nettype none
module itm_bus_master
    import itm_pkg::*;
(
    input  wire logic                  clock,
    input  wire logic [ITM_DATA_W-1:0] readdata,
    output logic      [ITM_ADDR_W-1:0] address,
    output logic                       chipselect,
    output logic                       write,
    output logic                       read,
    output logic      [ITM_DATA_W-1:0] writedata
);
    // idle bus from time zero
    initial begin
        address    = 3'h7;
        chipselect = 1'b0;
        write      = 1'b0;
        read       = 1'b0;
        writedata  = 16'h0000;
    end

    // one transfer, entered just after an edge; request held across the taking edge
    task automatic xfer(input logic wr, input logic [ITM_ADDR_W-1:0] ofs,
                        input logic [ITM_DATA_W-1:0] data, output logic [ITM_DATA_W-1:0] rd);
        logic [ITM_DATA_W-1:0] mask;
        mask       = (ofs == ITM_OFS_STATUS) ? 16'h0001 : (ofs == ITM_OFS_CONTROL) ? 16'h000f : 16'hffff;
        chipselect = 1'b1;
        write      = wr;
        read       = !wr;
        address    = ofs;
        writedata  = wr ? (data & mask) : ~writedata;
        @(posedge clock);
        #1;
        rd         = readdata;
        chipselect = 1'b0;
        write      = 1'b0;
        read       = 1'b0;
        // released lines must not keep showing the last value
        address    = ~address;
        writedata  = ~writedata;
        @(posedge clock);
        #1;
    endtask
endmodule
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench
    import itm_pkg::*;
;
    logic                  clock;
    logic                  reset;
    logic [ITM_ADDR_W-1:0] address;
    logic                  chipselect;
    logic                  write;
    logic                  read;
    logic [ITM_DATA_W-1:0] writedata;
    logic [ITM_DATA_W-1:0] readdata;
    logic                  irq;
    logic [ITM_DATA_W-1:0] d1;
    logic [ITM_DATA_W-1:0] d2;
    logic [ITM_DATA_W-1:0] x;
    logic [ITM_CNT_W-1:0]  s1;
    logic [ITM_CNT_W-1:0]  s2;
    int                    n_mismatch;
    int                    checks_done;
    int                    seed;

    itm_top u_itm_top (.clock(clock), .reset(reset), .address(address), .chipselect(chipselect),
        .write(write), .read(read), .writedata(writedata), .readdata(readdata), .irq(irq));
    itm_bus_master u_itm_bus_master (.clock(clock), .readdata(readdata), .address(address),
        .chipselect(chipselect), .write(write), .read(read), .writedata(writedata));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic end_of_test;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] expected);
        checks_done++;
        if (seen !== expected) begin
            n_mismatch++;
            $display("FAIL t=%0t seen=%h expected=%h", $time, seen, expected);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        logic [15:0] r;
        u_itm_bus_master.xfer(1'b1, a, d, r);
    endtask

    task automatic rdv(input logic [2:0] a, output logic [15:0] r);
        u_itm_bus_master.xfer(1'b0, a, 16'h0000, r);
    endtask

    // snapshot request then both halves: next call's capture lands 6 cycles later
    task automatic snap(output logic [31:0] s);
        logic [15:0] lo;
        logic [15:0] hi;
        // either offset must request the capture, so pick one at random
        wr((($random(seed) & 1) != 0) ? ITM_OFS_SNAP_HI : ITM_OFS_SNAP_LO, 16'h0000);
        rdv(ITM_OFS_SNAP_LO, lo);
        rdv(ITM_OFS_SNAP_HI, hi);
        s = {hi, lo};
    endtask

    // bounded wait for the interrupt line
    task automatic wait_irq;
        for (int i = 0; irq !== 1'b1; i++) begin
            if (i == 400) begin
                n_mismatch++;
                end_of_test();
            end
            @(posedge clock);
            #1;
        end
    endtask

    // count value k cycles on, modulo a period of p+1 (k <= p+1)
    function automatic logic [31:0] wrap(input logic [31:0] s, input int k, input logic [31:0] p);
        return (s + p + 1 - k) % (p + 1);
    endfunction

    initial begin
        n_mismatch  = 0;
        checks_done = 0;
        seed        = 55;
        reset       = 1'b1;
        repeat (3) @(posedge clock);
        #1;
        check(readdata, 16'h0000);
        reset = 1'b0;
        // reset values and unmapped offsets
        for (int a = 0; a < 8; a++) begin
            rdv(a[2:0], x);
            check(x, (a == 2 || a == 3) ? 16'hffff : 16'h0000);
        end
        $display("test reset values done");
        // random period and control contents
        for (int n = 0; n < 8; n++) begin
            d1 = 16'($random(seed));
            d2 = 16'($random(seed));
            wr(ITM_OFS_PERIOD_LO, d1);
            wr(ITM_OFS_PERIOD_HI, d2);
            wr(3'h6, ~d1);
            rdv(ITM_OFS_PERIOD_LO, x);
            check(x, d1);
            rdv(ITM_OFS_PERIOD_HI, x);
            check(x, d2);
            snap(s1);
            check(s1, {d2, d1});
            d1 = 16'($random(seed)) & 16'h0003;
            wr(ITM_OFS_CONTROL, d1);
            rdv(ITM_OFS_CONTROL, x);
            check(x, d1);
        end
        $display("test random registers done");
        // one-shot with interrupt enabled
        wr(ITM_OFS_PERIOD_LO, 16'h0014);
        wr(ITM_OFS_PERIOD_HI, 16'h0000);
        wr(ITM_OFS_CONTROL, 16'h0005);
        snap(s1);
        check(s1, 32'h0000_0013);
        snap(s2);
        check(s2, 32'h0000_000d);
        rdv(ITM_OFS_STATUS, x);
        check(x, 16'h0002);
        wait_irq();
        rdv(ITM_OFS_STATUS, x);
        check(x, 16'h0001);
        snap(s1);
        check(s1, 32'h0000_0014);
        // a one in bit 0 must leave the flag set
        wr(ITM_OFS_STATUS, 16'h0001);
        rdv(ITM_OFS_STATUS, x);
        check(x, 16'h0001);
        wr(ITM_OFS_CONTROL, 16'h0000);
        check(irq, 1'b0);
        wr(ITM_OFS_CONTROL, 16'h0001);
        check(irq, 1'b1);
        wr(ITM_OFS_STATUS, 16'h0000);
        check(irq, 1'b0);
        $display("test one-shot done");
        // continuous mode, period of ten cycles
        wr(ITM_OFS_PERIOD_LO, 16'h0009);
        wr(ITM_OFS_CONTROL, 16'h0006);
        for (int n = 0; n < 5; n++) begin
            snap(s1);
            snap(s2);
            check(s2, wrap(s1, 6, 32'h9));
        end
        wr(ITM_OFS_STATUS, 16'h0000);
        rdv(ITM_OFS_STATUS, x);
        check(x[1], 1'b1);
        $display("test continuous done");
        // stop, zero start bit, restart from held value
        wr(ITM_OFS_CONTROL, 16'h000a);
        snap(s1);
        snap(s2);
        check(s2, s1);
        rdv(ITM_OFS_STATUS, x);
        check(x[1], 1'b0);
        wr(ITM_OFS_CONTROL, 16'h0002);
        snap(s2);
        check(s2, s1);
        wr(ITM_OFS_CONTROL, 16'h0006);
        snap(s2);
        check(s2, wrap(s1, 1, 32'h9));
        $display("test start stop done");
        end_of_test();
    end
endmodule
`default_nettype wire
